// ### hdl/acac_cfg.svh
`ifndef ACAC_CFG_SVH
`define ACAC_CFG_SVH

`define ACAC_CLK_HZ        100000000
`define ACAC_CLK_NS        10
`define ACAC_WAKE_NS       25000
`define ACAC_WAKE_CYC      (`ACAC_WAKE_NS / `ACAC_CLK_NS)
`define ACAC_PULSE_NS      8000
`define ACAC_PULSE_CYC     (`ACAC_PULSE_NS / `ACAC_CLK_NS)
`define ACAC_SPS_0         8
`define ACAC_SPS_1         16
`define ACAC_SPS_2         32
`define ACAC_SPS_3         64
`define ACAC_SPS_4         128
`define ACAC_SPS_5         250
`define ACAC_SPS_6         475
`define ACAC_SPS_7         860
`define ACAC_TMR_W         24

`define ACAC_OFS_CONFIG    8'h00
`define ACAC_OFS_RESULT    8'h04
`define ACAC_OFS_UPPER     8'h08
`define ACAC_OFS_LOWER     8'h0C
`define ACAC_OFS_STATUS    8'h10

`define ACAC_BIT_MODE      0
`define ACAC_BIT_START     1
`define ACAC_BIT_RATE_LO   2
`define ACAC_BIT_RATE_HI   4
`define ACAC_BIT_WINDOW    5
`define ACAC_BIT_POL       6
`define ACAC_BIT_LATCH     7
`define ACAC_BIT_QUEUE_LO  8
`define ACAC_BIT_QUEUE_HI  9

`define ACAC_QUEUE_OFF     2'h3
`define ACAC_QUEUE_RST     2'h3
`define ACAC_RATE_RST      3'h4
`define ACAC_UPPER_RST     16'h7FFF
`define ACAC_LOWER_RST     16'h8000
`define ACAC_GCALL_RESET   8'h06
`define ACAC_LIMIT_TOP     15

`endif

// ### hdl/acac_pkg.sv
package acac_pkg;

    typedef enum logic [2:0] {
        ACAC_ST_PDOWN = 3'b001,
        ACAC_ST_WAKE  = 3'b010,
        ACAC_ST_CONV  = 3'b100
    } acac_state_t;

    typedef struct packed {
        logic [1:0] queue;
        logic       latch;
        logic       pol;
        logic       window;
        logic [2:0] rate;
        logic       mode;
    } acac_cfg_t;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [7:0]  address;
        logic [31:0] writedata;
        logic [3:0]  byteenable;
    } acac_avm_req_t;

    typedef struct packed {
        acac_state_t st;
        acac_cfg_t   cfg;
        acac_cfg_t   acfg;
        logic        start;
        logic [15:0] upper;
        logic [15:0] lower;
        logic [15:0] result;
        logic [23:0] tmr;
        logic [9:0]  pulse;
        logic [2:0]  qcnt;
        logic        alert;
        logic        alert_hi;
        logic        rdy;
        logic        ack;
        logic [31:0] rdata;
    } acac_reg_t;

endpackage : acac_pkg

// ### hdl/acac_top.sv
`timescale 1ns/1ps
`include "acac_cfg.svh"

module acac_top #(
    parameter int unsigned CONV_CYC [8] = '{
        `ACAC_CLK_HZ / `ACAC_SPS_0, `ACAC_CLK_HZ / `ACAC_SPS_1,
        `ACAC_CLK_HZ / `ACAC_SPS_2, `ACAC_CLK_HZ / `ACAC_SPS_3,
        `ACAC_CLK_HZ / `ACAC_SPS_4, `ACAC_CLK_HZ / `ACAC_SPS_5,
        `ACAC_CLK_HZ / `ACAC_SPS_6, `ACAC_CLK_HZ / `ACAC_SPS_7}
) (
    input  wire logic                   mclk,
    input  wire logic                   nrst,
    input  wire acac_pkg::acac_avm_req_t avm_req,
    output logic                        avm_waitrequest,
    output logic [31:0]                 avm_readdata,
    input  wire logic [15:0]            adc_result,
    output logic                        analog_power_on,
    output logic                        conversion_busy,
    input  wire logic                   gcall_valid,
    input  wire logic [7:0]             gcall_cmd,
    input  wire logic                   ara_won,
    output logic                        ara_respond,
    output logic                        ara_status,
    output logic                        alert_o,
    output logic                        alert_oe
);
    import acac_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////

    localparam acac_cfg_t CFG_RST = '{
        queue:  `ACAC_QUEUE_RST,
        latch:  1'b0,
        pol:    1'b0,
        window: 1'b0,
        rate:   `ACAC_RATE_RST,
        mode:   1'b1
    };

    localparam acac_reg_t REG_RST = '{
        st:       ACAC_ST_PDOWN,
        cfg:      CFG_RST,
        acfg:     CFG_RST,
        start:    1'b0,
        upper:    `ACAC_UPPER_RST,
        lower:    `ACAC_LOWER_RST,
        result:   16'h0000,
        tmr:      24'h000000,
        pulse:    10'h000,
        qcnt:     3'h0,
        alert:    1'b0,
        alert_hi: 1'b0,
        rdy:      1'b0,
        ack:      1'b0,
        rdata:    32'h00000000
    };

    acac_reg_t  q;
    acac_reg_t  d;
    logic       req;
    logic       rdy_mode;
    logic       enabled;
    logic       asserted;
    logic       pin_level;
    logic       above;
    logic       below;
    logic       out_lim;
    logic [2:0] need;
    logic [2:0] qnext;
    logic       trig;
    logic [15:0] wmask;

    function automatic logic [23:0] conv_load(input logic [2:0] rate);
        conv_load = 24'(CONV_CYC[rate] - 1);
    endfunction : conv_load

    ////////////////////////////////////////////////////////////////////////////////
    // Ready signalling is chosen live from the limit registers and the queue setting.

    assign rdy_mode  = q.upper[`ACAC_LIMIT_TOP] & ~q.lower[`ACAC_LIMIT_TOP]
                     & (q.cfg.queue != `ACAC_QUEUE_OFF);
    assign enabled   = (q.cfg.queue != `ACAC_QUEUE_OFF);
    assign asserted  = rdy_mode ? q.rdy : q.alert;
    assign pin_level = asserted ? q.cfg.pol : ~q.cfg.pol;
    // The pin is only ever pulled low; a high level is left to the pull-up.
    assign alert_o   = 1'b0;
    assign alert_oe  = enabled & ~pin_level;

    assign ara_respond     = q.alert & ~rdy_mode & enabled;
    assign ara_status      = q.alert_hi;
    assign avm_readdata    = q.rdata;
    assign analog_power_on = (q.st != ACAC_ST_PDOWN);
    assign conversion_busy = (q.st != ACAC_ST_PDOWN);

    assign req             = (avm_req.read | avm_req.write) & ~q.ack;
    assign avm_waitrequest = (avm_req.read | avm_req.write) & ~q.ack;
    assign wmask           = {{8{avm_req.byteenable[1]}}, {8{avm_req.byteenable[0]}}};

    ////////////////////////////////////////////////////////////////////////////////
    // Comparator inputs: live limit registers, with window and queue settings frozen at conversion start.

    always_comb begin
        above   = $signed(adc_result) > $signed(q.upper);
        below   = $signed(adc_result) < $signed(q.lower);
        out_lim = q.acfg.window ? (above | below) : above;
        case (q.acfg.queue)
            2'h0:    need = 3'h1;
            2'h1:    need = 3'h2;
            default: need = 3'h4;
        endcase
        qnext = out_lim ? ((q.qcnt == 3'h4) ? q.qcnt : q.qcnt + 3'h1) : 3'h0;
        // A disabled comparator must not leave a stale alert for a later enable.
        trig  = out_lim & (qnext >= need) & (q.acfg.queue != `ACAC_QUEUE_OFF);
    end

    ////////////////////////////////////////////////////////////////////////////////

    always_comb begin
        d     = q;
        d.ack = req;

        // Register bus: one wait cycle, answer on the second edge.
        if (req && avm_req.write) begin
            case (avm_req.address)
                `ACAC_OFS_CONFIG: begin
                    if (avm_req.byteenable[0]) begin
                        d.cfg.mode   = avm_req.writedata[`ACAC_BIT_MODE];
                        d.cfg.rate   = avm_req.writedata[`ACAC_BIT_RATE_HI:`ACAC_BIT_RATE_LO];
                        d.cfg.window = avm_req.writedata[`ACAC_BIT_WINDOW];
                        d.cfg.pol    = avm_req.writedata[`ACAC_BIT_POL];
                        d.cfg.latch  = avm_req.writedata[`ACAC_BIT_LATCH];
                        if (avm_req.writedata[`ACAC_BIT_START] && q.st == ACAC_ST_PDOWN) begin
                            d.start = 1'b1;
                        end
                    end
                    if (avm_req.byteenable[1]) begin
                        d.cfg.queue = avm_req.writedata[`ACAC_BIT_QUEUE_HI:`ACAC_BIT_QUEUE_LO];
                    end
                end
                `ACAC_OFS_UPPER: d.upper = (q.upper & ~wmask) | (avm_req.writedata[15:0] & wmask);
                `ACAC_OFS_LOWER: d.lower = (q.lower & ~wmask) | (avm_req.writedata[15:0] & wmask);
                default: ;
            endcase
        end

        if (req && avm_req.read) begin
            case (avm_req.address)
                `ACAC_OFS_CONFIG: d.rdata = {22'h000000, q.cfg.queue, q.cfg.latch, q.cfg.pol,
                                             q.cfg.window, q.cfg.rate, q.start, q.cfg.mode};
                `ACAC_OFS_RESULT: begin
                    d.rdata = {16'h0000, q.result};
                    d.alert = 1'b0;
                end
                `ACAC_OFS_UPPER:  d.rdata = {16'h0000, q.upper};
                `ACAC_OFS_LOWER:  d.rdata = {16'h0000, q.lower};
                `ACAC_OFS_STATUS: d.rdata = {26'h0000000, rdy_mode, asserted, q.alert_hi,
                                             q.alert, analog_power_on, conversion_busy};
                default:          d.rdata = 32'h00000000;
            endcase
        end

        // Winning arbitration on the alert response clears the latched alert.
        if (ara_won && ara_respond) begin
            d.alert = 1'b0;
        end

        // Continuous ready pulse times out here; a new end of conversion below wins.
        if (q.pulse != 10'h000) begin
            d.pulse = q.pulse - 10'h001;
        end else if (q.acfg.mode == 1'b0 && rdy_mode) begin
            d.rdy = 1'b0;
        end

        case (q.st)
            ACAC_ST_PDOWN: begin
                if (q.cfg.mode == 1'b0 || q.start) begin
                    d.st  = ACAC_ST_WAKE;
                    d.tmr = 24'(`ACAC_WAKE_CYC - 1);
                end
            end
            ACAC_ST_WAKE: begin
                if (q.tmr == 24'h000000) begin
                    d.st    = ACAC_ST_CONV;
                    d.start = 1'b0;
                    d.acfg  = d.cfg;
                    d.tmr   = conv_load(d.cfg.rate);
                    d.rdy   = 1'b0;
                end else begin
                    d.tmr = q.tmr - 24'h000001;
                end
            end
            ACAC_ST_CONV: begin
                if (q.tmr == 24'h000000) begin
                    d.result = adc_result;
                    d.qcnt   = qnext;
                    if (rdy_mode) begin
                        d.rdy = 1'b1;
                        if (q.acfg.mode == 1'b0) begin
                            d.pulse = 10'(`ACAC_PULSE_CYC - 1);
                        end
                    end else if (trig) begin
                        // A set wins over a clear made in the same cycle.
                        d.alert    = 1'b1;
                        d.alert_hi = q.acfg.window ? above : 1'b1;
                    end else if (!q.acfg.latch) begin
                        if (q.acfg.window ? !out_lim : below) begin
                            d.alert = 1'b0;
                        end
                    end
                    // The live mode setting picks restart or power-down; new settings take the next conversion.
                    if (q.cfg.mode == 1'b0) begin
                        d.acfg = q.cfg;
                        d.tmr  = conv_load(q.cfg.rate);
                    end else begin
                        d.st = ACAC_ST_PDOWN;
                    end
                end else begin
                    d.tmr = q.tmr - 24'h000001;
                end
            end
            default: d.st = ACAC_ST_PDOWN;
        endcase

        // General-call reset acts as a power-up; the bus handshake still completes, but the read data keeps its previous value.
        if (gcall_valid && gcall_cmd == `ACAC_GCALL_RESET) begin
            d       = REG_RST;
            d.ack   = req;
            d.rdata = q.rdata;
        end
    end

    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            q <= REG_RST;
        end else begin
            q <= d;
        end
    end

endmodule : acac_top

// ### tb/acac_chk_sva.sv
`timescale 1ns/1ps
module acac_chk (
    input wire logic                    mclk,
    input wire logic                    nrst,
    input wire acac_pkg::acac_avm_req_t avm_req,
    input wire logic                    avm_waitrequest,
    input wire logic [31:0]             avm_readdata,
    input wire logic [15:0]             adc_result,
    input wire logic                    analog_power_on,
    input wire logic                    conversion_busy,
    input wire logic                    gcall_valid,
    input wire logic [7:0]              gcall_cmd,
    input wire logic                    ara_won,
    input wire logic                    ara_respond,
    input wire logic                    ara_status,
    input wire logic                    alert_o,
    input wire logic                    alert_oe
);
    import acac_pkg::*;
    logic [15:0] on_q;
    logic        req;
    assign req = avm_req.read | avm_req.write;
////////////////////////////////////////////////////////////////////////////////
    // Counts powered cycles so a short wake can be caught at power-down.
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            on_q <= 16'h0000;
        end else begin
            on_q <= analog_power_on ? on_q + 16'h0001 : 16'h0000;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!nrst);
////////////////////////////////////////////////////////////////////////////////
    chk_wait_one: assert property (req && avm_waitrequest |=> !avm_waitrequest)
        else $error("bus request not answered after one wait cycle");
    chk_wait_idle: assert property (!req |-> !avm_waitrequest)
        else $error("wait raised with no request");
    chk_od_data: assert property (alert_o == 1'b0)
        else $error("alert pin driven high");
    chk_busy_power: assert property (analog_power_on == conversion_busy)
        else $error("busy and power disagree");
    chk_wake_min: assert property ($fell(analog_power_on) && !$past(gcall_valid)
        |-> on_q > 16'h09C4) else $error("powered down before wake and conversion");
    chk_ara_clear: assert property (ara_won && ara_respond && !conversion_busy
        |=> !ara_respond) else $error("alert kept after won response");
    chk_ara_keep: assert property (ara_respond && !ara_won && !req && !$past(req)
        && !gcall_valid && !conversion_busy |=> ara_respond) else $error("alert lost");
    chk_gcall_rst: assert property (gcall_valid && gcall_cmd == 8'h06
        |=> !analog_power_on && !alert_oe && !ara_respond) else $error("no general reset");
    chk_rst_idle: assert property ($rose(nrst) |-> !analog_power_on && !alert_oe)
        else $error("not idle after reset");
    chk_rd_upper: assert property (avm_req.read && !avm_waitrequest
        |-> avm_readdata[31:16] == 16'h0000) else $error("upper read bits set");
endmodule : acac_chk

// ### tb/acac_far_model.sv
`timescale 1ns/1ps
module acac_far_model (
    input wire logic    mclk,
    input wire logic    ara_respond,
    output logic [15:0] adc_result,
    output logic        gcall_valid,
    output logic [7:0]  gcall_cmd,
    output logic        ara_won
);
    initial begin
        adc_result = 16'h0000;
        gcall_valid = 1'b0;
        gcall_cmd = 8'h00;
        ara_won = 1'b0;
    end
    task set_sample(input logic [15:0] v);
        @(posedge mclk);
        adc_result <= v;
    endtask : set_sample
    task gcall(input logic [7:0] c);
        @(posedge mclk);
        gcall_valid <= 1'b1;
        gcall_cmd <= c;
        @(posedge mclk);
        gcall_valid <= 1'b0;
        // The byte is gone once the strobe drops, so it must not linger.
        gcall_cmd <= ~c;
    endtask : gcall
    // A lost arbitration is played by answering with win low.
    task alert_resp(input logic win);
        for (int i = 0; i < 4 && ara_respond === 1'b1; i++) begin
            @(posedge mclk);
            ara_won <= win;
            @(posedge mclk);
            ara_won <= 1'b0;
            @(posedge mclk);
        end
    endtask : alert_resp
endmodule : acac_far_model

// ### tb/tb.sv
`timescale 1ns/1ps
module tb;
    import acac_pkg::*;
    localparam int unsigned CC [8] = '{1000, 100, 100, 100, 100, 100, 100, 100};
    localparam logic [7:0]  RA [4] = '{8'h00, 8'h08, 8'h0C, 8'h14};
    localparam logic [31:0] RV [4] = '{32'h311, 32'h7FFF, 32'h8000, 32'h0};
    localparam int          NEED [4] = '{1, 2, 4, 5};
    logic          mclk, nrst, avm_waitrequest, analog_power_on, conversion_busy;
    logic          gcall_valid, ara_won, ara_respond, ara_status, alert_o, alert_oe;
    acac_avm_req_t avm_req;
    logic [31:0]   avm_readdata, rd;
    logic [15:0]   adc_result;
    logic [7:0]    gcall_cmd;
    int            miscompares, num_checks, n, q, k;
    acac_top #(.CONV_CYC(CC)) uut (.mclk, .nrst, .avm_req, .avm_waitrequest, .avm_readdata,
        .adc_result, .analog_power_on, .conversion_busy, .gcall_valid, .gcall_cmd,
        .ara_won, .ara_respond, .ara_status, .alert_o, .alert_oe);
    acac_far_model far (.mclk, .ara_respond, .adc_result, .gcall_valid, .gcall_cmd, .ara_won);
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
////////////////////////////////////////////////////////////////////////////////
    task end_of_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : end_of_test
    task chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
            miscompares++;
        end
    endtask : chk
    task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        @(posedge mclk);
        n = 0;
        avm_req <= '{read: !wr, write: wr, address: a, writedata: d, byteenable: 4'h3};
        do begin
            @(posedge mclk);
            n++;
        end while (avm_waitrequest !== 1'b0 && n < 20);
        if (n == 20) begin
            miscompares++;
            end_of_test();
        end
        rd = avm_readdata;
        avm_req <= '0;
    endtask : bus
    // Waits on the power (sel high) or the pin drive; n ends as the cycle count.
    task wt(input logic sel, input logic lvl, input int lim);
        n = 0;
        while ((sel ? analog_power_on : alert_oe) !== lvl && n < lim) begin
            @(posedge mclk);
            n++;
        end
        if (n == lim) begin
            miscompares++;
            end_of_test();
        end
    endtask : wt
    task conv(input logic [15:0] v, input logic [31:0] cfg, input logic twice);
        far.set_sample(v);
        bus(1'b1, 8'h00, cfg);
        wt(1'b1, 1'b1, 10);
        if (twice) begin
            bus(1'b1, 8'h00, cfg);
        end
        wt(1'b1, 1'b0, 4000);
        repeat (2) @(posedge mclk);
    endtask : conv
////////////////////////////////////////////////////////////////////////////////
    initial begin
        miscompares = 0;
        num_checks = 0;
        nrst = 1'b0;
        avm_req = '0;
        repeat (20) @(posedge mclk);
        nrst <= 1'b1;
        repeat (100) @(posedge mclk);
        for (q = 0; q < 4; q++) begin
            bus(1'b0, RA[q], 32'h0);
            chk(rd, RV[q]);
        end
        chk({30'h0, analog_power_on, alert_oe}, 32'h0);
        $display("test reset done");
        bus(1'b1, 8'h08, 32'h0100);
        bus(1'b1, 8'h0C, 32'hFF00);
        conv(16'h0200, 32'h00B3, 1'b0);
        chk({30'h0, ara_status, alert_oe}, 32'h3);
        conv(16'h0000, 32'h00B3, 1'b0);
        chk(32'(alert_oe), 32'h1);
        bus(1'b0, 8'h04, 32'h0);
        chk({rd[30:0], alert_oe}, 32'h0);
        conv(16'hF000, 32'h00B3, 1'b1);
        repeat (100) @(posedge mclk);
        chk({analog_power_on, ara_status, alert_oe}, 32'h1);
        far.alert_resp(1'b0);
        chk(32'(alert_oe), 32'h1);
        far.alert_resp(1'b1);
        chk(32'(alert_oe), 32'h0);
        $display("test latch done");
        for (q = 0; q < 4; q++) begin
            conv(16'h0000, 32'h0033 | (q << 8), 1'b0);
            for (k = 1; k <= (q == 3 ? 4 : NEED[q]); k++) begin
                conv(16'h0200, 32'h0033 | (q << 8), 1'b0);
                chk(32'(alert_oe), 32'(k >= NEED[q]));
            end
        end
        conv(16'h0200, 32'h0013, 1'b0);
        conv(16'h0000, 32'h0013, 1'b0);
        chk(32'(alert_oe), 32'h1);
        conv(16'hF000, 32'h0013, 1'b0);
        chk(32'(alert_oe), 32'h0);
        $display("test comparator done");
        bus(1'b1, 8'h08, 32'h8000);
        bus(1'b1, 8'h0C, 32'h0000);
        conv(16'h0000, 32'h00B3, 1'b0);
        chk(32'(alert_oe), 32'h1);
        bus(1'b1, 8'h00, 32'h0000);
        wt(1'b0, 1'b0, 5000);
        wt(1'b0, 1'b1, 3000);
        wt(1'b0, 1'b0, 2000);
        chk(n, 32'h320);
        k = n;
        wt(1'b0, 1'b1, 2000);
        chk(k + n, CC[0]);
        far.gcall(8'h06);
        repeat (2) @(posedge mclk);
        bus(1'b0, 8'h00, 32'h0);
        chk({rd[29:0], analog_power_on, alert_oe}, 32'hC44);
        $display("test ready done");
        bus(1'b1, 8'h08, 32'h0100);
        conv(16'h0000, 32'h0053, 1'b0);
        chk(32'(alert_oe), 32'h1);
        conv(16'h0200, 32'h0053, 1'b0);
        chk(32'(alert_oe), 32'h0);
        bus(1'b0, 8'h10, 32'h0);
        chk(rd, 32'h1C);
        far.gcall(8'h07);
        repeat (2) @(posedge mclk);
        bus(1'b0, 8'h00, 32'h0);
        chk(rd, 32'h51);
        $display("test polarity done");
        end_of_test();
    end
endmodule : tb

bind acac_top acac_chk chk_i (.mclk, .nrst, .avm_req, .avm_waitrequest, .avm_readdata,
    .adc_result, .analog_power_on, .conversion_busy, .gcall_valid, .gcall_cmd, .ara_won,
    .ara_respond, .ara_status, .alert_o, .alert_oe);
